/* gssi_pkg.sv */
/*
 package for the rate-sensor serial slave: instruction codes, frame
 sizes, register map positions, response layouts and timing constants.
 assumes a 40 MHz system clock and a mode 0 serial master.
*/
package gssi_pkg;
    // ----------------------------------------
    // clock and link timing
    // ----------------------------------------
    localparam int SYS_CLK_HZ = 40000000;
    localparam int SCLK_MIN_HALF_NS = 63;
    localparam int SCLK_MIN_HALF_CYC =
        (SCLK_MIN_HALF_NS * (SYS_CLK_HZ / 1000000) + 999) / 1000;

    // ----------------------------------------
    // instructions and argument lengths
    // ----------------------------------------
    localparam logic [7:0] OP_RATE = 8'h50;
    localparam logic [7:0] OP_TEMP = 8'h54;
    localparam logic [7:0] OP_ADV_RD = 8'h58;
    localparam logic [7:0] OP_ADV_WR = 8'h78;
    localparam logic [7:0] OP_ADV_SEL = 8'h7C;
    localparam logic [3:0] ARG_BYTES_2 = 4'h2;
    localparam logic [3:0] ARG_BYTES_4 = 4'h4;
    localparam logic [3:0] ARG_BYTES_8 = 4'h8;

    // ----------------------------------------
    // system register and memory map
    // ----------------------------------------
    localparam int ADDR_W = 6;
    localparam int MEM_DEPTH = 64;
    localparam logic [5:0] ADDR_SLOTS = 6'h02;
    localparam logic [5:0] ADDR_TEMP_CAL = 6'h09;
    localparam logic [5:0] ADDR_RATE_FIRST = 6'h2E;
    localparam logic [5:0] ADDR_RATE_LAST = 6'h33;
    localparam int RATE_CAL_DIS_BIT = 27;
    localparam int TEMP_CAL_SEL_BIT = 2;
    localparam logic [3:0] RATE_WRITE_LIMIT = 4'h7;
    localparam logic [3:0] OTHER_WRITE_LIMIT = 4'h1;
    localparam logic [31:0] SF_SETTING = 32'h0000_2710;

    // ----------------------------------------
    // response layouts, link pin bundle and frame states
    // ----------------------------------------
    typedef struct packed {
        logic [23:0] rate;
        logic [5:0] pad;
        logic new_sample_flag;
        logic selftest_ok_flag;
    } gssi_rate_word_s;

    typedef struct packed {
        logic [3:0] pad;
        logic [11:0] temp;
    } gssi_temp_word_s;

    typedef struct packed {
        logic sclk;
        logic mosi;
        logic select_n;
    } gssi_link_in_s;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_OPCODE = 2'b01,
        ST_ARG = 2'b10,
        ST_DONE = 2'b11
    } gssi_state_e;
endpackage : gssi_pkg

/* gssi_sync.sv */
/*
 two flip-flop synchroniser for a bundle of link pins.
 assumes the pins are asynchronous to sys_clk.
*/
`timescale 1ns/1ps
module gssi_sync #(
    parameter int WIDTH = 3,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stage1 <= RESET_VALUE;
            sync_out <= RESET_VALUE;
        end
        else if (clk_en)
        begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end
endmodule : gssi_sync

/* gssi_slave.sv */
/*
 serial slave front end of the rate sensor: frame decode, rate and
 temperature responses, system registers and programmable memory.
 assumes a mode 0 master with sclk far slower than sys_clk.
*/
`timescale 1ns/1ps
module gssi_slave (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic sclk,
    input wire logic mosi,
    input wire logic select_n,
    input wire logic reset_n_input,
    input wire logic sample_strobe,
    input wire logic [23:0] raw_rate,
    input wire logic [23:0] comp_rate,
    input wire logic [11:0] temp_raw,
    input wire logic [11:0] temp_cal,
    input wire logic drive_amp_stable,
    output logic miso,
    output logic miso_oe,
    output logic selftest_ok_flag,
    output logic rate_cal_disable,
    output logic temp_cal_select,
    output logic write_refused
);
    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    gssi_pkg::gssi_link_in_s link_raw;
    gssi_pkg::gssi_link_in_s link;
    logic rst_pin_s;
    assign link_raw = '{sclk: sclk, mosi: mosi, select_n: select_n};

    gssi_sync #(.WIDTH(3), .RESET_VALUE(3'h1)) u_link_sync (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .async_in(link_raw),
        .sync_out(link)
    );
    gssi_sync #(.WIDTH(1), .RESET_VALUE(1'h1)) u_rst_sync (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .async_in(reset_n_input),
        .sync_out(rst_pin_s)
    );

    // ----------------------------------------
    // edge detection
    // ----------------------------------------
    logic sclk_d;
    logic sel_d;
    logic rst_pin_d;
    wire sclk_rise = link.sclk & ~sclk_d;
    wire sclk_fall = ~link.sclk & sclk_d;
    wire frame_start = ~link.select_n & sel_d;
    wire frame_end = link.select_n & ~sel_d;
    wire reload = ~rst_pin_s & rst_pin_d;

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sclk_d <= 1'b0;
            sel_d <= 1'b1;
            rst_pin_d <= 1'b1;
        end
        else if (clk_en)
        begin
            sclk_d <= link.sclk;
            sel_d <= link.select_n;
            rst_pin_d <= rst_pin_s;
        end
    end

    // ----------------------------------------
    // memory and system registers
    // ----------------------------------------
    // power-up state: unprogrammed, no writes spent, defaults all zero
    logic [31:0] mem [gssi_pkg::MEM_DEPTH] = '{default: 32'h0000_0000};
    logic [3:0] mem_writes [gssi_pkg::MEM_DEPTH] = '{default: 4'h0};
    logic [31:0] sysreg [gssi_pkg::MEM_DEPTH] = '{default: 32'h0000_0000};

    function automatic logic [3:0] write_limit(
        input logic [gssi_pkg::ADDR_W-1:0] a
    );
        if (a >= gssi_pkg::ADDR_RATE_FIRST && a <= gssi_pkg::ADDR_RATE_LAST)
            write_limit = gssi_pkg::RATE_WRITE_LIMIT;
        else
            write_limit = gssi_pkg::OTHER_WRITE_LIMIT;
    endfunction : write_limit

    // ----------------------------------------
    // frame engine
    // ----------------------------------------
    gssi_pkg::gssi_state_e state;
    gssi_pkg::gssi_state_e next_state;
    logic [7:0] opcode;
    logic [63:0] shift_in;
    logic [63:0] shift_out;
    logic [6:0] bit_cnt;
    logic [6:0] arg_bits;
    logic [5:0] adv_addr;
    logic adv_to_mem;
    logic ready_flag;

    function automatic logic [6:0] arg_len(input logic [7:0] op);
        case (op)
            gssi_pkg::OP_ADV_WR: arg_len = {gssi_pkg::ARG_BYTES_8, 3'h0};
            gssi_pkg::OP_TEMP,
            gssi_pkg::OP_ADV_SEL: arg_len = {gssi_pkg::ARG_BYTES_2, 3'h0};
            default: arg_len = {gssi_pkg::ARG_BYTES_4, 3'h0};
        endcase
    endfunction : arg_len

    wire [7:0] op_now = {shift_in[6:0], link.mosi};
    wire opcode_done = (state == gssi_pkg::ST_OPCODE) && sclk_rise &&
        (bit_cnt == 7'h07);
    wire arg_done = (state == gssi_pkg::ST_ARG) && sclk_rise &&
        (bit_cnt == arg_bits - 7'h01);
    wire [63:0] arg_now = {shift_in[62:0], link.mosi};

    // calibrated or raw two's complement rate
    wire [23:0] rate_sel = rate_cal_disable ? raw_rate : comp_rate;
    // rate in upper bits, flags in lowest two
    gssi_pkg::gssi_rate_word_s rate_word;
    assign rate_word = '{rate: rate_sel, pad: 6'h00,
        new_sample_flag: ready_flag, selftest_ok_flag: selftest_ok_flag};
    // 12-bit unsigned, calibrated only when selected
    gssi_pkg::gssi_temp_word_s temp_word;
    assign temp_word = '{pad: 4'h0,
        temp: temp_cal_select ? temp_cal : temp_raw};
    wire [31:0] adv_data = adv_to_mem ? mem[adv_addr] : sysreg[adv_addr];

    function automatic logic [63:0] response(input logic [7:0] op,
        input logic [31:0] rw, input logic [15:0] tw,
        input logic [31:0] ad);
        case (op)
            gssi_pkg::OP_RATE: response = {rw, 32'h0000_0000};
            gssi_pkg::OP_TEMP: response = {tw, 48'h0000_0000_0000};
            gssi_pkg::OP_ADV_RD: response = {ad, 32'h0000_0000};
            default: response = 64'h0000_0000_0000_0000;
        endcase
    endfunction : response

    always_comb
    begin
        next_state = state;
        case (state)
            gssi_pkg::ST_IDLE:
                if (frame_start)
                    next_state = gssi_pkg::ST_OPCODE;
            gssi_pkg::ST_OPCODE:
                if (opcode_done)
                    next_state = gssi_pkg::ST_ARG;
            gssi_pkg::ST_ARG:
                if (arg_done)
                    next_state = gssi_pkg::ST_DONE;
            gssi_pkg::ST_DONE:
                next_state = gssi_pkg::ST_DONE;
            default:
                next_state = gssi_pkg::ST_IDLE;
        endcase
        if (frame_end)
            next_state = gssi_pkg::ST_IDLE;
    end

    // sample on rising, shift on falling
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= gssi_pkg::ST_IDLE;
            opcode <= 8'h00;
            shift_in <= 64'h0000_0000_0000_0000;
            shift_out <= 64'h0000_0000_0000_0000;
            bit_cnt <= 7'h00;
            arg_bits <= 7'h20;
        end
        else if (clk_en)
        begin
            state <= next_state;
            if (frame_start)
            begin
                bit_cnt <= 7'h00;
                shift_out <= 64'h0000_0000_0000_0000;
            end
            else if (sclk_rise && state != gssi_pkg::ST_DONE)
            begin
                shift_in <= arg_now;
                bit_cnt <= opcode_done ? 7'h00 : bit_cnt + 7'h01;
                if (opcode_done)
                begin
                    opcode <= op_now;
                    arg_bits <= arg_len(op_now);
                    shift_out <= response(op_now, rate_word, temp_word,
                        adv_data);
                end
            end
            else if (sclk_fall && state == gssi_pkg::ST_ARG && bit_cnt != 7'h00)
                shift_out <= {shift_out[62:0], 1'b0};
        end
    end

    // output enabled only inside a frame
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            miso <= 1'b0;
            miso_oe <= 1'b0;
        end
        else if (clk_en)
        begin
            miso_oe <= ~link.select_n;
            miso <= ~link.select_n & shift_out[63];
        end
    end

    // set wins over the read clear
    wire rate_read = arg_done && opcode == gssi_pkg::OP_RATE;
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            ready_flag <= 1'b0;
        else if (clk_en)
        begin
            if (sample_strobe)
                ready_flag <= 1'b1;
            else if (rate_read)
                ready_flag <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            selftest_ok_flag <= 1'b0;
        else if (clk_en && sample_strobe)
            selftest_ok_flag <= drive_amp_stable;
    end

    // ----------------------------------------
    // advanced access
    // ----------------------------------------
    // 0x7C selects location: arg[15] memory, arg[5:0] address.
    // 0x78 writes arg[63:32] to the selected location.
    wire adv_sel = arg_done && opcode == gssi_pkg::OP_ADV_SEL;
    wire adv_wr = arg_done && opcode == gssi_pkg::OP_ADV_WR;
    wire mem_ok = mem_writes[adv_addr] < write_limit(adv_addr);
    wire [31:0] wr_data = arg_now[63:32];

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            adv_addr <= 6'h00;
            adv_to_mem <= 1'b0;
            write_refused <= 1'b0;
        end
        else if (clk_en)
        begin
            if (adv_sel)
            begin
                adv_addr <= arg_now[5:0];
                adv_to_mem <= arg_now[15];
            end
            write_refused <= adv_wr & adv_to_mem & ~mem_ok;
        end
    end

    // memory has no reset, so contents survive
    always_ff @(posedge sys_clk)
    begin
        if (clk_en && adv_wr && adv_to_mem && mem_ok)
        begin
            mem[adv_addr] <= wr_data;
            mem_writes[adv_addr] <= mem_writes[adv_addr] + 4'h1;
        end
    end

    // reset pin reloads registers from memory
    always_ff @(posedge sys_clk)
    begin
        if (clk_en)
        begin
            if (reload)
            begin
                for (int i = 0; i < gssi_pkg::MEM_DEPTH; i++)
                    sysreg[i] <= mem[i];
            end
            else if (adv_wr && !adv_to_mem)
                sysreg[adv_addr] <= wr_data;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rate_cal_disable <= 1'b0;
            temp_cal_select <= 1'b0;
        end
        else if (clk_en)
        begin
            rate_cal_disable <=
                sysreg[gssi_pkg::ADDR_SLOTS][gssi_pkg::RATE_CAL_DIS_BIT];
            temp_cal_select <=
                sysreg[gssi_pkg::ADDR_TEMP_CAL][gssi_pkg::TEMP_CAL_SEL_BIT];
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb_sys @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_rate_done;
        clk_en && rate_read && !sample_strobe;
    endsequence

    a_miso_released: assert property (
        clk_en && link.select_n |=> !miso_oe)
        else $error("data out driven while deselected");
    a_flag_clear_read: assert property (
        s_rate_done |=> !ready_flag)
        else $error("ready flag not cleared by read");
    a_flag_set_wins: assert property (
        clk_en && sample_strobe |=> ready_flag)
        else $error("ready flag lost a new sample");
    a_selftest_follow: assert property (
        clk_en && sample_strobe |=> selftest_ok_flag == $past(drive_amp_stable))
        else $error("self-test flag not updated");
    a_limit_refused: assert property (
        clk_en && adv_wr && adv_to_mem && !mem_ok |=> write_refused)
        else $error("write over limit not refused");
    a_arg_length: assert property (
        clk_en && opcode_done && op_now == gssi_pkg::OP_ADV_WR
        |=> arg_bits == 7'h40)
        else $error("wrong argument length");
    a_cal_default: assert property (
        $rose(rst_n) |-> !rate_cal_disable && !temp_cal_select)
        else $error("calibration selects not cleared");
    a_frame_idle: assert property (
        clk_en && frame_end |=> state == gssi_pkg::ST_IDLE)
        else $error("frame not closed on deselect");
endmodule : gssi_slave

/* gssi_master_model.sv */
/*
 serial master model facing the rate-sensor slave: one opcode byte then
 2, 4 or 8 argument bytes, msb first, 200 ns per sclk.
 assumes a 40 MHz sys_clk and a single caller at a time.
*/
`timescale 1ns/1ps
module gssi_master_model (
    input wire logic sys_clk,
    input wire logic miso,
    output gssi_pkg::gssi_link_in_s link
);
    // ----------------------------------------
    // idle link
    // ----------------------------------------
    initial
    begin
        link = '{sclk: 1'b0, mosi: 1'b0, select_n: 1'b1};
    end

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : wait_cyc

    // ----------------------------------------
    // one frame
    // ----------------------------------------
    // mode 0 master
    task automatic frame(input logic [7:0] op, input logic [63:0] arg,
                         input int nbytes, output logic [63:0] rsp);
        logic [71:0] bits;
        int n;
        bits = {op, 64'h0} | ({8'h00, arg} << (64 - 8 * nbytes));
        n = 8 + 8 * nbytes;
        rsp = '0;
        link.select_n <= 1'b0;
        // select setup of one sclk period
        wait_cyc(8);
        for (int i = 0; i < n; i++)
        begin
            link.mosi <= bits[71 - i];
            wait_cyc(4);
            link.sclk <= 1'b1;
            wait_cyc(4);
            // sampled late in the high phase: the slave's pin synchroniser
            // puts miso too close to the rising edge at this sclk rate
            if (i >= 8)
                rsp = {rsp[62:0], miso};
            link.sclk <= 1'b0;
        end
        wait_cyc(8);
        link.select_n <= 1'b1;
        // released line shows no stale value
        link.mosi <= ~link.mosi;
        wait_cyc(8);
    endtask : frame
endmodule : gssi_master_model

/* gssi_slave_tb.sv */
/*
 self-checking bench for the rate-sensor serial slave.
 assumes the master model drives the link pins and gssi_pkg is compiled.
*/
`timescale 1ns/1ps
module gssi_slave_tb;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic clk_en = 1'b1;
    logic reset_n_input = 1'b1;
    logic sample_strobe = 1'b0;
    logic [23:0] raw_rate = 24'h000000;
    logic [23:0] comp_rate = 24'h000000;
    logic [11:0] temp_raw = 12'h000;
    logic [11:0] temp_cal = 12'h000;
    logic drive_amp_stable = 1'b0;
    logic miso, miso_oe, selftest_ok_flag, rate_cal_disable;
    logic temp_cal_select, write_refused;
    logic [31:0] n_refused = 32'h0;
    logic [31:0] d;
    logic [63:0] r;
    int mismatches = 0;
    int n_tests = 0;
    gssi_pkg::gssi_link_in_s link;

    always #12.5 sys_clk = ~sys_clk;

    // refusal is a one-cycle pulse, so it is counted
    always @(posedge sys_clk)
        if (write_refused === 1'b1)
            n_refused <= n_refused + 32'h1;

    gssi_master_model i_master (.sys_clk(sys_clk), .miso(miso), .link(link));

    gssi_slave i_dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
        .sclk(link.sclk), .mosi(link.mosi), .select_n(link.select_n),
        .reset_n_input(reset_n_input), .sample_strobe(sample_strobe),
        .raw_rate(raw_rate), .comp_rate(comp_rate), .temp_raw(temp_raw),
        .temp_cal(temp_cal), .drive_amp_stable(drive_amp_stable),
        .miso(miso), .miso_oe(miso_oe), .selftest_ok_flag(selftest_ok_flag),
        .rate_cal_disable(rate_cal_disable),
        .temp_cal_select(temp_cal_select), .write_refused(write_refused)
    );

    // ----------------------------------------
    // checks and expectations
    // ----------------------------------------
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
            mismatches++;
        end
    endtask : chk_word

    task automatic chk_bit(input logic got, input logic exp);
        n_tests++;
        if (got !== exp)
        begin
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
            mismatches++;
        end
    endtask : chk_bit

    function automatic logic [31:0] exp_rate(input logic [23:0] v,
                                             input logic rdy, input logic st);
        return {v, 6'h00, rdy, st};
    endfunction : exp_rate

    task automatic test_end(input string name);
        $display("test %s done", name);
    endtask : test_end

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : test_done

    // ----------------------------------------
    // stimulus helpers
    // ----------------------------------------
    task automatic new_sample(input logic [23:0] c);
        @(posedge sys_clk);
        raw_rate <= 24'($urandom);
        comp_rate <= c;
        drive_amp_stable <= 1'($urandom);
        sample_strobe <= 1'b1;
        @(posedge sys_clk);
        sample_strobe <= 1'b0;
        @(posedge sys_clk);
    endtask : new_sample

    // select then read or write: registers or memory by the mem bit
    task automatic adv(input logic mem, input logic [5:0] a, input logic wr,
                       input logic [31:0] data);
        i_master.frame(gssi_pkg::OP_ADV_SEL, {48'h0, mem, 9'h000, a}, 2, r);
        if (wr)
            i_master.frame(gssi_pkg::OP_ADV_WR, {data, 32'h0}, 8, r);
        else
            i_master.frame(gssi_pkg::OP_ADV_RD, 64'h0, 4, r);
        d = r[31:0];
    endtask : adv

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial
    begin
        void'($urandom(32'hEAD5));
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge sys_clk);
        chk_bit(miso_oe, 1'b0);
        chk_bit(temp_cal_select, 1'b0);
        test_end("reset");
        for (int k = 0; k < 4; k++)
        begin
            new_sample(k == 0 ? 24'hCA9820 : 24'($urandom));
            chk_bit(selftest_ok_flag, drive_amp_stable);
            i_master.frame(gssi_pkg::OP_RATE, 64'h0, 4, r);
            chk_word(r[31:0], exp_rate(comp_rate, 1'b1, drive_amp_stable));
            i_master.frame(gssi_pkg::OP_RATE, 64'h0, 4, r);
            chk_word(r[31:0], exp_rate(comp_rate, 1'b0, drive_amp_stable));
            chk_bit(miso_oe, 1'b0);
        end
        test_end("rate");
        temp_raw <= 12'($urandom);
        temp_cal <= 12'hFFF;
        i_master.frame(gssi_pkg::OP_TEMP, 64'h0, 2, r);
        chk_word(r[31:0], {20'h0, temp_raw});
        adv(1'b0, gssi_pkg::ADDR_TEMP_CAL, 1'b1, 32'h0000_0004);
        chk_bit(temp_cal_select, 1'b1);
        i_master.frame(gssi_pkg::OP_TEMP, 64'h0, 2, r);
        chk_word(r[31:0], {20'h0, temp_cal});
        test_end("temperature");
        adv(1'b1, gssi_pkg::ADDR_SLOTS, 1'b1, 32'h0);
        adv(1'b1, gssi_pkg::ADDR_SLOTS, 1'b1, 32'h0800_0000);
        chk_word(n_refused, 32'h1);
        adv(1'b0, gssi_pkg::ADDR_SLOTS, 1'b1, 32'h0800_0000);
        chk_bit(rate_cal_disable, 1'b1);
        new_sample(24'($urandom));
        i_master.frame(gssi_pkg::OP_RATE, 64'h0, 4, r);
        chk_word(r[31:0], exp_rate(raw_rate, 1'b1, drive_amp_stable));
        adv(1'b0, gssi_pkg::ADDR_SLOTS, 1'b0, 32'h0);
        chk_bit(d[gssi_pkg::RATE_CAL_DIS_BIT], 1'b1);
        reset_n_input <= 1'b0;
        repeat (4) @(posedge sys_clk);
        reset_n_input <= 1'b1;
        repeat (4) @(posedge sys_clk);
        chk_bit(rate_cal_disable, 1'b0);
        test_end("system registers");
        for (int k = 1; k <= 8; k++)
            adv(1'b1, gssi_pkg::ADDR_RATE_FIRST, 1'b1, 32'(k));
        chk_word(n_refused, 32'h2);
        rst_n <= 1'b0;
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        adv(1'b1, gssi_pkg::ADDR_RATE_FIRST, 1'b0, 32'h0);
        chk_word(d, 32'h0000_0007);
        test_end("memory");
        // frozen block must ignore a sample strobe
        clk_en <= 1'b0;
        drive_amp_stable <= ~selftest_ok_flag;
        sample_strobe <= 1'b1;
        @(posedge sys_clk);
        sample_strobe <= 1'b0;
        repeat (4) @(posedge sys_clk);
        chk_bit(selftest_ok_flag, ~drive_amp_stable);
        clk_en <= 1'b1;
        test_end("clock enable");
        test_done();
    end

    // about 15k cycles expected; a hang is cut well beyond that
    initial
    begin
        repeat (40000) @(posedge sys_clk);
        mismatches++;
        test_done();
    end
endmodule : gssi_slave_tb
